// file: dv/tb_wheel_event_power_mode_ctrl.sv
// Self-checking bench for the wheel event and power mode controller.
// Assumes a host model ends ready windows; one ms is shortened to MS cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_wheel_event_power_mode_ctrl;
   import wepmc_pkg::*;
   localparam int MS = 10;
   logic        clk, srst, regWr, regRd, angleValid, firstChanTouch, firstChanProx;
   logic        commWindowDone, readyOut, senseAllChannels, senseFirstOnly, userLogicRun, ackEn;
   logic [7:0]  regAddr, regWdata, regRdata, rdv, ackDelay;
   logic [8:0]  angleDeg;
   logic [1:0]  chanFreqMult, magFreqMult;
   logic [15:0] oscKhz, chanChargeKhz, magChargeKhz;
   wepmc_mode_t powerMode;
   int          bad_count = 0;
   int          comparisons = 0;
   int          n;

   wepmc_ctrl #(.MS_CYC(MS)) u_wepmc_ctrl (.clk(clk), .srst(srst), .regWr(regWr),
      .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .angleValid(angleValid), .angleDeg(angleDeg), .firstChanTouch(firstChanTouch),
      .firstChanProx(firstChanProx), .commWindowDone(commWindowDone), .readyOut(readyOut),
      .powerMode(powerMode), .senseAllChannels(senseAllChannels),
      .senseFirstOnly(senseFirstOnly), .userLogicRun(userLogicRun),
      .chanFreqMult(chanFreqMult), .magFreqMult(magFreqMult), .oscKhz(oscKhz),
      .chanChargeKhz(chanChargeKhz), .magChargeKhz(magChargeKhz));
   wepmc_host_model u_wepmc_host_model (.clk(clk), .srst(srst), .readyOut(readyOut),
      .ackEn(ackEn), .ackDelay(ackDelay), .commWindowDone(commWindowDone));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWr = 1'b1;
      step(1);
      regWr = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr = a;
      regRd = 1'b1;
      step(1);
      regRd = 1'b0;
      d = regRdata;
      step(1);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
      logic [7:0] d;
      rd(a, d);
      chk(nm, 16'(exp), 16'(d));
   endtask
   task automatic ang(input logic [8:0] d);
      angleDeg = d;
      angleValid = 1'b1;
      step(1);
      angleValid = 1'b0;
      step(3);
   endtask
   task automatic await_ready(input int lim);
      n = 0;
      while (readyOut !== 1'b1 && n < lim) begin
         step(1);
         n++;
      end
   endtask
   task automatic clr;
      ackEn = 1'b1;
      step(10);
      ackEn = 1'b0;
      step(1);
   endtask
   task automatic close_out;
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(4 * 20000);
      bad_count++;
      close_out();
   end

   initial begin
      srst = 1'b1;
      {regWr, regRd, angleValid, firstChanTouch, firstChanProx, ackEn} = 6'h00;
      {regAddr, regWdata, ackDelay} = 24'h000000;
      angleDeg = 9'h000;
      step(2);
      srst = 1'b0;
      rdc(ADDR_ROT_UI, ROT_UI_RST, "rot_ui");
      rdc(ADDR_DIVIDER, DIVIDER_RST, "divider");
      rdc(8'h55, 8'h00, "unmapped");
      wr(ADDR_PWR_MODE, 8'h20);
      chk("mode", PM_NORMAL, powerMode);
      wr(ADDR_CH_SENSE, 8'h30);
      wr(ADDR_MAG_SENSE, 8'h10);
      wr(ADDR_GEN_SYS, 8'h10);
      step(1);
      chk("osc", 16'(OSC_SLOW_KHZ), oscKhz);
      chk("chan_charge", 16'(OSC_SLOW_KHZ / 2 * 4), chanChargeKhz);
      chk("mag_charge", 16'(OSC_SLOW_KHZ / 2 * 2), magChargeKhz);
      wr(ADDR_GEN_SYS, 8'h00);
      step(1);
      chk("chan_charge", 16'(OSC_FAST_KHZ / 2 * 4), chanChargeKhz);
      wr(ADDR_NORM_RATE, 8'h03);
      ackDelay = 8'h05;
      clr();
      await_ready(3 * MS + 4);
      chk("stream_ready", 16'h0001, readyOut);
      ackDelay = 8'h00;
      wr(ADDR_DIVIDER, 8'h24);
      wr(ADDR_ROT_UI, 8'h14);
      wr(ADDR_GEN_SYS, 8'h20);
      clr();
      step(4 * MS);
      chk("event_quiet", 16'h0000, readyOut);
      ang(9'h01E);
      ang(9'h024);
      rdc(ADDR_INTERVAL, 8'h00, "interval");
      ang(9'h025);
      chk("interval_ready", 16'h0001, readyOut);
      rdc(ADDR_INTERVAL, 8'h01, "interval");
      clr();
      ang(9'h024);
      rdc(ADDR_INTERVAL, 8'h01, "interval");
      ang(9'h023);
      rdc(ADDR_INTERVAL, 8'h00, "interval");
      chk("interval_ready", 16'h0001, readyOut);
      wr(ADDR_ROT_UI, 8'h1D);
      clr();
      firstChanTouch = 1'b1;
      await_ready(4 * MS);
      chk("touch_ready", 16'h0001, readyOut);
      clr();
      await_ready(4 * MS);
      chk("touch_repeat", 16'h0001, readyOut);
      firstChanTouch = 1'b0;
      clr();
      ang(9'h050);
      chk("touch_mask", 16'h0000, readyOut);
      wr(ADDR_ROT_UI, 8'h1C);
      clr();
      ang(9'h078);
      chk("no_source", 16'h0000, readyOut);
      wr(ADDR_WAKE_PRE, 8'h00);
      wr(ADDR_ROT_UI, 8'h0C);
      clr();
      ang(9'h0A0);
      ang(9'h0C8);
      await_ready(2 * MS);
      chk("wheel_ready", 16'h0001, readyOut);
      rdc(ADDR_WAKE_PRE, AWAKE_PRELOAD, "preload");
      wr(ADDR_PWR_MODE, 8'h38);
      clr();
      chk("mode", PM_HALT, powerMode);
      ang(9'h000);
      step(4 * MS);
      chk("halt_ready", 16'h0000, readyOut);
      wr(ADDR_PWR_MODE, 8'h20);
      chk("mode", PM_NORMAL, powerMode);
      wr(ADDR_LINK_SET, 8'h20);
      clr();
      await_ready(4 * MS);
      chk("stream_normal", 16'h0001, readyOut);
      wr(ADDR_DWELL, 8'h01);
      wr(ADDR_PWR_MODE, 8'h00);
      n = 0;
      while (powerMode === PM_NORMAL && n < 600 * MS) begin
         step(1);
         n++;
      end
      chk("dwell", 16'h0001, 16'(n >= 480 * MS && n <= 520 * MS));
      step(2);
      chk("auto_mode", PM_LOW, powerMode);
      chk("low_ui", 16'h0000, userLogicRun);
      clr();
      step(4 * MS);
      chk("low_no_stream", 16'h0000, readyOut);
      wr(ADDR_ULP_RATE, 8'h01);
      wr(ADDR_PWR_MODE, 8'h70);
      step(3);
      chk("mode", PM_ULTRA_LOW, powerMode);
      chk("first_only", 16'h0001, senseFirstOnly);
      step(40 * MS);
      rd(ADDR_SYS_FLAGS, rdv);
      chk("ulp_flag", 16'h0001, 16'(rdv[FLAG_ULP_UPDATE]));
      wr(ADDR_PWR_MODE, 8'h40);
      firstChanProx = 1'b1;
      step(2);
      chk("prox_wake", PM_NORMAL, powerMode);
      firstChanProx = 1'b0;
      wr(ADDR_OFFSET_LO, 8'h12);
      wr(ADDR_ROT_UI, 8'h34);
      step(2);
      ang(9'h030);
      ang(9'h036);
      rdc(ADDR_INTERVAL, 8'h00, "offset_interval");
      ang(9'h037);
      rdc(ADDR_INTERVAL, 8'h01, "offset_interval");
      close_out();
   end
endmodule
`default_nettype wire

// file: dv/wepmc_ctrl_sva.sv
// Port-level checker for the wheel event and power mode controller.
// Assumes it is bound to wepmc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wepmc_ctrl_sva #(
   parameter int MS_CYC = wepmc_pkg::MS_CYCLES
) (
   input wire logic                   clk,
   input wire logic                   srst,
   input wire logic                   regWr,
   input wire logic [7:0]             regAddr,
   input wire logic [7:0]             regWdata,
   input wire logic                   commWindowDone,
   input wire logic                   readyOut,
   input wire wepmc_pkg::wepmc_mode_t powerMode,
   input wire logic                   senseAllChannels,
   input wire logic                   senseFirstOnly,
   input wire logic                   userLogicRun,
   input wire logic [1:0]             chanFreqMult,
   input wire logic [1:0]             magFreqMult,
   input wire logic [15:0]            oscKhz,
   input wire logic [15:0]            chanChargeKhz,
   input wire logic [15:0]            magChargeKhz
);
   import wepmc_pkg::*;
   logic       slowOsc_r;
   logic [1:0] chanMult_r;
   logic [1:0] magMult_r;

   // Last written clock and multiplier settings, as the host sees them
   always_ff @(posedge clk) begin
      if (srst) begin
         slowOsc_r <= 1'b0;
         chanMult_r <= 2'h0;
         magMult_r <= 2'h0;
      end else if (regWr) begin
         if (regAddr == ADDR_GEN_SYS) slowOsc_r <= regWdata[GEN_SLOW_OSC];
         if (regAddr == ADDR_CH_SENSE) chanMult_r <= regWdata[FREQ_MULT_LO +: 2];
         if (regAddr == ADDR_MAG_SENSE) magMult_r <= regWdata[FREQ_MULT_LO +: 2];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_done_clears_ready: assert property (commWindowDone |=> !readyOut)
      else $error("ready still high after window done");
   a_ready_level_holds: assert property (readyOut && !commWindowDone |=> readyOut)
      else $error("ready dropped without window done");
   a_halt_no_ready: assert property (powerMode == PM_HALT && $past(powerMode) == PM_HALT
      && !readyOut && !regWr |=> !readyOut) else $error("ready raised in halt");
   a_osc_select: assert property ($stable(slowOsc_r) [*2] |->
      oscKhz == (slowOsc_r ? 16'(OSC_SLOW_KHZ) : 16'(OSC_FAST_KHZ)))
      else $error("oscillator rate does not follow setting");
   a_mult_fields: assert property (($stable(chanMult_r) && $stable(magMult_r)) [*2] |->
      chanFreqMult == chanMult_r && magFreqMult == magMult_r)
      else $error("multiplier field does not follow register");
   a_chan_charge: assert property (($stable(oscKhz) && $stable(chanFreqMult)) [*2] |->
      chanChargeKhz == (oscKhz >> 1) * (16'h0001 + 16'(chanFreqMult)))
      else $error("channel charge rate wrong");
   a_mag_charge: assert property (($stable(oscKhz) && $stable(magFreqMult)) [*2] |->
      magChargeKhz == (oscKhz >> 1) * (16'h0001 + 16'(magFreqMult)))
      else $error("magnetic charge rate wrong");
   a_mode_forced: assert property (regWr && regAddr == ADDR_PWR_MODE && regWdata[PWR_AUTO_DIS]
      && (regWdata[4:3] != 2'h2 || regWdata[PWR_ULP_EN]) |->
      ##2 2'(powerMode) == $past(regWdata[4:3], 2)) else $error("forced mode not applied");
   a_halt_idle: assert property (powerMode == PM_HALT && $past(powerMode) == PM_HALT |->
      !senseAllChannels && !senseFirstOnly && !userLogicRun) else $error("sensing in halt");
   a_low_no_ui: assert property ((powerMode == PM_LOW || powerMode == PM_ULTRA_LOW)
      && $past(powerMode) == powerMode |-> !userLogicRun) else $error("user logic in low mode");
endmodule
bind wepmc_ctrl wepmc_ctrl_sva #(.MS_CYC(MS_CYC)) u_wepmc_ctrl_sva (
   .clk(clk), .srst(srst), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
   .commWindowDone(commWindowDone), .readyOut(readyOut), .powerMode(powerMode),
   .senseAllChannels(senseAllChannels), .senseFirstOnly(senseFirstOnly),
   .userLogicRun(userLogicRun), .chanFreqMult(chanFreqMult), .magFreqMult(magFreqMult),
   .oscKhz(oscKhz), .chanChargeKhz(chanChargeKhz), .magChargeKhz(magChargeKhz));
`default_nettype wire

// file: dv/wepmc_host_model.sv
// Host side of the ready line: ends the window after a chosen delay.
// Assumes the same clock as the controller; the bench gates it with ackEn.
`timescale 1ns/1ps
`default_nettype none
module wepmc_host_model (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       readyOut,
   input wire logic       ackEn,
   input wire logic [7:0] ackDelay,
   output logic           commWindowDone
);
   logic [7:0] waitCnt_r;

   // One stop pulse per window, after ackDelay + 1 cycles of ready
   always_ff @(posedge clk) begin
      if (srst || !readyOut || !ackEn || commWindowDone) begin
         waitCnt_r <= 8'h00;
         commWindowDone <= 1'b0;
      end else if (waitCnt_r >= ackDelay) begin
         commWindowDone <= 1'b1;
      end else begin
         waitCnt_r <= waitCnt_r + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: hw/wepmc_ctrl.sv
// Wheel interval counter, wake detector, event source select and power mode sequencer.
// Assumes the serial front end presents byte reads and writes as one-cycle strobes,
// the angle engine supplies degrees 0..359 with a valid strobe, and sensing front
// ends report the first channel touch and proximity as levels.
`timescale 1ns/1ps
`default_nettype none
module wepmc_ctrl #(
   parameter int MS_CYC = wepmc_pkg::MS_CYCLES
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   input  wire logic [7:0]              regAddr,
   input  wire logic [7:0]              regWdata,
   output logic      [7:0]              regRdata,
   input  wire logic                    angleValid,
   input  wire logic [8:0]              angleDeg,
   input  wire logic                    firstChanTouch,
   input  wire logic                    firstChanProx,
   input  wire logic                    commWindowDone,
   output logic                         readyOut,
   output wepmc_pkg::wepmc_mode_t       powerMode,
   output logic                         senseAllChannels,
   output logic                         senseFirstOnly,
   output logic                         userLogicRun,
   output logic      [1:0]              chanFreqMult,
   output logic      [1:0]              magFreqMult,
   output logic      [15:0]             oscKhz,
   output logic      [15:0]             chanChargeKhz,
   output logic      [15:0]             magChargeKhz
);
   import wepmc_pkg::*;

   logic [7:0]  sysFlags_r, uiFlags_r, interval_r, chSense_r, rotUi_r, magSense_r;
   logic [7:0]  wakePre_r, divider_r, moveTimer_r, moveCount_r, genSys_r, pwrMode_r;
   logic [7:0]  normRate_r, lpRate_r, ulpRate_r, dwell_r, linkSet_r;
   logic [15:0] offset_r;
   logic [8:0]  prevAngle_r, boundLo_r;
   logic        angleSeen_r, zeroReq_r;
   logic [8:0]  relAngle, stepDeg;
   logic        moveDir;
   logic        intervalUp, intervalDn, wheelWake, eventHit;
   wepmc_mode_t mode_r, modeNxt;
   logic [31:0] msDiv_r, periodCnt_r, dwellCnt_r;
   logic        msTick, periodTick;
   logic [31:0] periodMs;

   function automatic logic [8:0] wrapDeg(input logic [9:0] v);
      wrapDeg = (v >= {1'b0, FULL_TURN}) ? 9'(v - {1'b0, FULL_TURN}) : v[8:0];
   endfunction

   // Register writes; zero wheel request self clears, awake reloads preload
   always_ff @(posedge clk) begin
      if (srst) begin
         chSense_r  <= 8'h00;
         rotUi_r    <= ROT_UI_RST;
         magSense_r <= 8'h00;
         wakePre_r  <= WAKE_PRE_RST;
         divider_r  <= DIVIDER_RST;
         offset_r   <= 16'h0000;
         genSys_r   <= 8'h00;
         pwrMode_r  <= 8'h00;
         normRate_r <= 8'h00;
         lpRate_r   <= 8'h00;
         ulpRate_r  <= 8'h00;
         dwell_r    <= 8'h00;
         linkSet_r  <= 8'h00;
      end else begin
         if (regWr) begin
            case (regAddr)
               ADDR_CH_SENSE:  chSense_r  <= regWdata;
               ADDR_ROT_UI:    rotUi_r    <= regWdata;
               ADDR_MAG_SENSE: magSense_r <= regWdata;
               ADDR_WAKE_PRE:  wakePre_r  <= regWdata;
               ADDR_DIVIDER:   divider_r  <= regWdata;
               ADDR_OFFSET_LO: offset_r[7:0]  <= regWdata;
               ADDR_OFFSET_HI: offset_r[15:8] <= regWdata;
               ADDR_GEN_SYS:   genSys_r   <= regWdata;
               ADDR_PWR_MODE:  pwrMode_r  <= regWdata;
               ADDR_NORM_RATE: normRate_r <= regWdata;
               ADDR_LP_RATE:   lpRate_r   <= regWdata;
               ADDR_ULP_RATE:  ulpRate_r  <= regWdata;
               ADDR_DWELL:     dwell_r    <= regWdata;
               ADDR_LINK_SET:  linkSet_r  <= regWdata;
               default: ;
            endcase
         end
         if (zeroReq_r)
            rotUi_r[ROT_ZERO_WHEEL] <= 1'b0;
         if (wheelWake && wakePre_r == 8'h00)
            wakePre_r <= AWAKE_PRELOAD;
      end
   end

   // Wheel angle relative to offset, step and direction since last sample
   always_comb begin
      relAngle = wrapDeg(10'(angleDeg) + 10'(FULL_TURN) - 10'(offset_r[8:0] % FULL_TURN));
      stepDeg  = wrapDeg(10'(relAngle) + 10'(FULL_TURN) - 10'(prevAngle_r));
      moveDir  = (stepDeg != 9'h000) && (stepDeg < 9'(FULL_TURN >> 1));
      if (!moveDir && stepDeg != 9'h000)
         stepDeg = 9'(FULL_TURN - stepDeg);
   end

   // Interval boundaries need to be passed by one degree before a change
   always_comb begin
      intervalUp = 1'b0;
      intervalDn = 1'b0;
      if (angleValid && angleSeen_r && divider_r != 8'h00 && !zeroReq_r) begin
         intervalUp = wrapDeg(10'(relAngle) + 10'(FULL_TURN) - 10'(boundLo_r))
                      >= 9'(divider_r) + HYST_DEG &&
                      wrapDeg(10'(relAngle) + 10'(FULL_TURN) - 10'(boundLo_r))
                      < 9'(FULL_TURN >> 1);
         intervalDn = wrapDeg(10'(boundLo_r) + 10'(FULL_TURN) - 10'(relAngle))
                      >= HYST_DEG &&
                      wrapDeg(10'(boundLo_r) + 10'(FULL_TURN) - 10'(relAngle))
                      < 9'(FULL_TURN >> 1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         interval_r  <= 8'h00;
         boundLo_r   <= 9'h000;
         prevAngle_r <= 9'h000;
         angleSeen_r <= 1'b0;
         zeroReq_r   <= 1'b0;
      end else begin
         zeroReq_r <= rotUi_r[ROT_ZERO_WHEEL];
         // First sample after zeroing only sets the reference angle
         if (zeroReq_r) begin
            interval_r  <= 8'h00;
            boundLo_r   <= 9'h000;
            angleSeen_r <= 1'b0;
         end else if (regWr && regAddr == ADDR_INTERVAL) begin
            interval_r <= regWdata;
         end else if (angleValid) begin
            angleSeen_r <= 1'b1;
            prevAngle_r <= relAngle;
            if (intervalUp) begin
               interval_r <= interval_r + 8'h01;
               boundLo_r  <= wrapDeg(10'(boundLo_r) + 10'(divider_r));
            end else if (intervalDn) begin
               interval_r <= interval_r - 8'h01;
               boundLo_r  <= wrapDeg(10'(boundLo_r) + 10'(FULL_TURN) - 10'(divider_r));
            end
         end
      end
   end

   // Movement counter and wake timer
   // Timer steps once per angle sample; a zero preload removes the time limit
   always_ff @(posedge clk) begin
      if (srst) begin
         moveCount_r <= 8'h00;
         moveTimer_r <= 8'h00;
         wheelWake   <= 1'b0;
         uiFlags_r   <= 8'h00;
      end else begin
         wheelWake <= 1'b0;
         if (angleValid && angleSeen_r) begin
            uiFlags_r <= {6'h00, moveDir, stepDeg != 9'h000};
            if (wakePre_r != 8'h00 && moveTimer_r == 8'h00) begin
               moveCount_r <= 8'h00;
               moveTimer_r <= wakePre_r;
            end else begin
               if (wakePre_r != 8'h00)
                  moveTimer_r <= moveTimer_r - 8'h01;
               if (9'(moveCount_r) + stepDeg >= 9'(divider_r)) begin
                  wheelWake   <= 1'b1;
                  moveCount_r <= 8'h00;
                  moveTimer_r <= wakePre_r;
               end else begin
                  moveCount_r <= 8'(9'(moveCount_r) + stepDeg);
               end
            end
         end
      end
   end

   // Source select: touch masks others, wheel beats interval
   // The interval and wheel fields are disables; touch wake is an enable
   always_comb begin
      if (rotUi_r[ROT_TOUCH_WAKE])
         eventHit = firstChanTouch;
      else if (!rotUi_r[ROT_WHEEL_EV])
         eventHit = wheelWake;
      else if (!rotUi_r[ROT_INTERVAL_EV])
         eventHit = intervalUp || intervalDn;
      else
         eventHit = 1'b0;
   end

   // Millisecond base and report period
   // A zero period ticks every millisecond
   always_comb begin
      case (mode_r)
         PM_NORMAL:    periodMs = 32'(normRate_r) * NORM_STEP_MS;
         PM_LOW:       periodMs = 32'(lpRate_r) * LP_STEP_MS;
         PM_ULTRA_LOW: periodMs = 32'(ulpRate_r) * ULP_STEP_MS;
         default:      periodMs = 32'h0000_0000;
      endcase
   end

   assign msTick     = (msDiv_r == 32'(MS_CYC - 1));
   assign periodTick = (mode_r != PM_HALT) && msTick &&
                       (periodCnt_r + 32'h1 >= periodMs);

   always_ff @(posedge clk) begin
      if (srst) begin
         msDiv_r     <= 32'h0;
         periodCnt_r <= 32'h0;
      end else begin
         msDiv_r <= msTick ? 32'h0 : msDiv_r + 32'h1;
         if (periodTick || modeNxt != mode_r)
            periodCnt_r <= 32'h0;
         else if (msTick)
            periodCnt_r <= periodCnt_r + 32'h1;
      end
   end

   // Power mode sequencer
   always_comb begin
      modeNxt = mode_r;
      if (pwrMode_r[PWR_AUTO_DIS]) begin
         modeNxt = wepmc_mode_t'(pwrMode_r[PWR_MODE_LO +: 2]);
      end else begin
         case (mode_r)
            PM_NORMAL:
               if (dwellCnt_r >= 32'(dwell_r) * DWELL_STEP_MS)
                  modeNxt = PM_LOW;
            PM_LOW:
               if (eventHit || firstChanTouch)
                  modeNxt = PM_NORMAL;
               else if (pwrMode_r[PWR_ULP_EN] &&
                        dwellCnt_r >= 32'(dwell_r) * DWELL_STEP_MS)
                  modeNxt = PM_ULTRA_LOW;
            PM_ULTRA_LOW:
               if (firstChanProx || eventHit)
                  modeNxt = PM_NORMAL;
            // Halt is left only by a forced mode write
            PM_HALT: modeNxt = PM_HALT;
            default: modeNxt = PM_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_r     <= PM_NORMAL;
         dwellCnt_r <= 32'h0;
      end else begin
         mode_r <= modeNxt;
         if (modeNxt != mode_r || eventHit)
            dwellCnt_r <= 32'h0;
         else if (msTick)
            dwellCnt_r <= dwellCnt_r + 32'h1;
      end
   end

   // Ultra-low periodic full update flag; set wins over the acknowledge write
   always_ff @(posedge clk) begin
      if (srst) begin
         sysFlags_r <= 8'h00;
      end else begin
         if (regWr && regAddr == ADDR_GEN_SYS)
            sysFlags_r[FLAG_ULP_UPDATE] <= 1'b0;
         if (mode_r == PM_ULTRA_LOW && periodTick)
            sysFlags_r[FLAG_ULP_UPDATE] <= 1'b1;
      end
   end

   // Ready: held until the host ends its window
   // Stream-in-normal streams in normal mode and falls back to events elsewhere
   always_ff @(posedge clk) begin
      if (srst) begin
         readyOut <= 1'b0;
      end else if (commWindowDone) begin
         readyOut <= 1'b0;
      end else if (!genSys_r[GEN_EVENT_MODE]) begin
         if (periodTick)
            readyOut <= 1'b1;
      end else if (linkSet_r[LINK_STREAM_NORM] && mode_r == PM_NORMAL) begin
         if (periodTick)
            readyOut <= 1'b1;
      end else if (eventHit && mode_r != PM_HALT) begin
         readyOut <= 1'b1;
      end
   end

   // Sensing plan and clocks
   always_ff @(posedge clk) begin
      if (srst) begin
         senseAllChannels <= 1'b0;
         senseFirstOnly   <= 1'b0;
         userLogicRun     <= 1'b0;
         oscKhz           <= 16'(OSC_FAST_KHZ);
         chanFreqMult     <= 2'b00;
         magFreqMult      <= 2'b00;
         chanChargeKhz    <= 16'(OSC_FAST_KHZ / 2);
         magChargeKhz     <= 16'(OSC_FAST_KHZ / 2);
      end else begin
         senseAllChannels <= mode_r == PM_NORMAL || mode_r == PM_LOW ||
                             (mode_r == PM_ULTRA_LOW && periodTick);
         senseFirstOnly   <= mode_r == PM_ULTRA_LOW;
         userLogicRun     <= mode_r == PM_NORMAL;
         oscKhz <= genSys_r[GEN_SLOW_OSC] ? 16'(OSC_SLOW_KHZ) : 16'(OSC_FAST_KHZ);
         chanFreqMult  <= chSense_r[FREQ_MULT_LO +: 2];
         magFreqMult   <= magSense_r[FREQ_MULT_LO +: 2];
         chanChargeKhz <= 16'((oscKhz >> 1) * (16'(chSense_r[FREQ_MULT_LO +: 2]) + 16'h1));
         magChargeKhz  <= 16'((oscKhz >> 1) * (16'(magSense_r[FREQ_MULT_LO +: 2]) + 16'h1));
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_SYS_FLAGS: regRdata <= sysFlags_r;
            ADDR_UI_FLAGS:  regRdata <= uiFlags_r;
            ADDR_INTERVAL:  regRdata <= interval_r;
            ADDR_CH_SENSE:  regRdata <= chSense_r;
            ADDR_ROT_UI:    regRdata <= rotUi_r;
            ADDR_MAG_SENSE: regRdata <= magSense_r;
            ADDR_WAKE_PRE:  regRdata <= wakePre_r;
            ADDR_DIVIDER:   regRdata <= divider_r;
            ADDR_OFFSET_LO: regRdata <= offset_r[7:0];
            ADDR_OFFSET_HI: regRdata <= offset_r[15:8];
            ADDR_MOVE_CT:   regRdata <= moveTimer_r;
            ADDR_GEN_SYS:   regRdata <= genSys_r;
            ADDR_PWR_MODE:  regRdata <= pwrMode_r;
            ADDR_NORM_RATE: regRdata <= normRate_r;
            ADDR_LP_RATE:   regRdata <= lpRate_r;
            ADDR_ULP_RATE:  regRdata <= ulpRate_r;
            ADDR_DWELL:     regRdata <= dwell_r;
            ADDR_LINK_SET:  regRdata <= linkSet_r;
            default:        regRdata <= 8'h00;
         endcase
      end
   end

   assign powerMode = mode_r;
endmodule
`default_nettype wire

// file: hw/wepmc_pkg.sv
// Package for the wheel event and power mode controller.
// Assumes a single 250 MHz clock domain and byte-wide register access.
package wepmc_pkg;
   localparam logic [7:0] ADDR_SYS_FLAGS   = 8'h10;
   localparam logic [7:0] ADDR_UI_FLAGS    = 8'h14;
   localparam logic [7:0] ADDR_INTERVAL    = 8'h18;
   localparam logic [7:0] ADDR_CH_SENSE    = 8'h42;
   localparam logic [7:0] ADDR_ROT_UI      = 8'h70;
   localparam logic [7:0] ADDR_MAG_SENSE   = 8'h71;
   localparam logic [7:0] ADDR_WAKE_PRE    = 8'h7C;
   localparam logic [7:0] ADDR_DIVIDER     = 8'h7D;
   localparam logic [7:0] ADDR_OFFSET_LO   = 8'h7E;
   localparam logic [7:0] ADDR_OFFSET_HI   = 8'h7F;
   localparam logic [7:0] ADDR_MOVE_CT     = 8'h8F;
   localparam logic [7:0] ADDR_GEN_SYS     = 8'hD0;
   localparam logic [7:0] ADDR_PWR_MODE    = 8'hD2;
   localparam logic [7:0] ADDR_NORM_RATE   = 8'hD3;
   localparam logic [7:0] ADDR_LP_RATE     = 8'hD4;
   localparam logic [7:0] ADDR_ULP_RATE    = 8'hD5;
   localparam logic [7:0] ADDR_DWELL       = 8'hD6;
   localparam logic [7:0] ADDR_LINK_SET    = 8'hD9;

   // Field positions
   localparam int ROT_TOUCH_WAKE   = 0;
   localparam int ROT_INTERVAL_EV  = 3;
   localparam int ROT_WHEEL_EV     = 4;
   localparam int ROT_ZERO_WHEEL   = 5;
   localparam int GEN_SLOW_OSC     = 4;
   localparam int GEN_EVENT_MODE   = 5;
   localparam int PWR_MODE_LO      = 3;
   localparam int PWR_AUTO_DIS     = 5;
   localparam int PWR_ULP_EN       = 6;
   localparam int LINK_STREAM_NORM = 5;
   localparam int FLAG_ULP_UPDATE  = 0;
   localparam int FREQ_MULT_LO     = 4;

   // Reset values, wake preload and wheel constants
   localparam logic [7:0] DIVIDER_RST  = 8'h03;
   localparam logic [7:0] ROT_UI_RST   = 8'h14;
   localparam logic [7:0] WAKE_PRE_RST = 8'h00;
   localparam logic [7:0] AWAKE_PRELOAD = 8'h1F;
   localparam logic [8:0] FULL_TURN    = 9'h168;
   localparam logic [8:0] HYST_DEG     = 9'h001;

   // Timing
   localparam int CLK_MHZ       = 250;
   localparam int MS_US         = 1000;
   localparam int MS_CYCLES     = CLK_MHZ * MS_US;
   localparam int NORM_STEP_MS  = 1;
   localparam int LP_STEP_MS    = 1;
   localparam int ULP_STEP_MS   = 16;
   localparam int DWELL_STEP_MS = 500;
   localparam int OSC_FAST_KHZ  = 16000;
   localparam int OSC_SLOW_KHZ  = 8000;

   typedef enum logic [1:0] {
      PM_NORMAL, PM_LOW, PM_ULTRA_LOW, PM_HALT
   } wepmc_mode_t;
endpackage
